// ---- design/dfrg_ramp_gen.sv ----
`timescale 1ns/1ps
module dfrg_ramp_gen
  import dfrg_pkg::*;
#(
  parameter int NUM_DI = 4,
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
  // clock, reset, enable
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  // terminal pins
  input wire logic [NUM_DI-1:0] di_pins,
  input wire logic run_cmd,
  input wire logic jog_req,
  // same-domain control
  input wire logic motor2_sel,
  input wire logic pid_alarm,
  input wire logic fault_halt_req,
  input wire logic [FREQ_W-1:0] freq_ref,
  // configuration, taken on cfg_load
  input wire logic cfg_load,
  input wire logic [TIME_W-1:0] accel_time_set1,
  input wire logic [TIME_W-1:0] decel_time_set1,
  input wire logic [TIME_W-1:0] accel_time_set2,
  input wire logic [TIME_W-1:0] decel_time_set2,
  input wire logic [TIME_W-1:0] quick_halt_time,
  input wire logic ramp_time_unit_select,
  input wire logic [TIME_W-1:0] inch_accel_time,
  input wire logic [TIME_W-1:0] inch_decel_time,
  input wire logic [TIME_W-1:0] scurve_accel_start,
  input wire logic [TIME_W-1:0] scurve_accel_end,
  input wire logic [TIME_W-1:0] scurve_decel_start,
  input wire logic [TIME_W-1:0] scurve_decel_end,
  input wire logic [FREQ_W-1:0] max_output_freq,
  input wire logic [FREQ_W-1:0] motor2_max_output_freq,
  input wire logic [FREQ_W-1:0] freq_cmd_upper_limit,
  input wire logic [FREQ_W-1:0] inch_freq_cmd,
  input wire logic [FREQ_W-1:0] disconnect_fallback_freq,
  input wire logic [NUM_DI*FUNC_W-1:0] digital_input_function_select,
  input wire logic [FUNC_W-1:0] digital_output_function_select,
  // outputs
  output logic [FREQ_W-1:0] out_freq_q,
  output logic halt_dout_q,
  output logic halt_latched_q,
  output logic at_target_q
);
  function automatic logic [TIME_W-1:0] sat(input logic [TIME_W-1:0] v,
    input logic [TIME_W-1:0] lim);
    sat = (v > lim) ? lim : v;
  endfunction

  function automatic logic [FREQ_W-1:0] fmin(input logic [FREQ_W-1:0] a,
    input logic [FREQ_W-1:0] b);
    fmin = (a < b) ? a : b;
  endfunction

  // configuration registers
  logic [TIME_W-1:0] acc1_q, dec1_q, acc2_q, dec2_q, halt_t_q;
  logic [TIME_W-1:0] iacc_q, idec_q, sas_q, sae_q, sds_q, sde_q;
  logic unit_q;
  logic [FREQ_W-1:0] fmax1_q, fmax2_q, flim_q, inch_q, fb_q;
  logic [NUM_DI*FUNC_W-1:0] di_fn_q;
  logic [FUNC_W-1:0] do_fn_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      acc1_q <= RAMP_TIME_DEF;
      dec1_q <= RAMP_TIME_DEF;
      acc2_q <= RAMP_TIME_DEF;
      dec2_q <= RAMP_TIME_DEF;
      halt_t_q <= RAMP_TIME_DEF;
      iacc_q <= RAMP_TIME_DEF;
      idec_q <= RAMP_TIME_DEF;
      sas_q <= SCURVE_DEF;
      sae_q <= SCURVE_DEF;
      sds_q <= SCURVE_DEF;
      sde_q <= SCURVE_DEF;
      unit_q <= UNIT_SEL_DEF;
      fmax1_q <= FMAX_DEF;
      fmax2_q <= FMAX_DEF;
      flim_q <= UPPER_LIMIT_DEF;
      inch_q <= '0;
      fb_q <= FALLBACK_DEF;
      di_fn_q <= '0;
      do_fn_q <= '0;
    end else if (ce && cfg_load) begin
      acc1_q <= sat(accel_time_set1, RAMP_TIME_MAX);
      dec1_q <= sat(decel_time_set1, RAMP_TIME_MAX);
      acc2_q <= sat(accel_time_set2, RAMP_TIME_MAX);
      dec2_q <= sat(decel_time_set2, RAMP_TIME_MAX);
      halt_t_q <= sat(quick_halt_time, HALT_TIME_MAX);
      iacc_q <= sat(inch_accel_time, RAMP_TIME_MAX);
      idec_q <= sat(inch_decel_time, RAMP_TIME_MAX);
      sas_q <= sat(scurve_accel_start, SCURVE_MAX);
      sae_q <= sat(scurve_accel_end, SCURVE_MAX);
      sds_q <= sat(scurve_decel_start, SCURVE_MAX);
      sde_q <= sat(scurve_decel_end, SCURVE_MAX);
      unit_q <= ramp_time_unit_select;
      fmax1_q <= max_output_freq;
      fmax2_q <= motor2_max_output_freq;
      flim_q <= freq_cmd_upper_limit;
      inch_q <= inch_freq_cmd;
      fb_q <= disconnect_fallback_freq;
      di_fn_q <= digital_input_function_select;
      do_fn_q <= digital_output_function_select;
    end
  end

  // pin synchronisers
  logic [NUM_DI+1:0] pin_m_q, pin_s_q;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
    end else if (ce) begin
      pin_m_q <= {jog_req, run_cmd, di_pins};
      pin_s_q <= pin_m_q;
    end
  end
  wire [NUM_DI-1:0] di_s = pin_s_q[NUM_DI-1:0];
  wire run_s = pin_s_q[NUM_DI];
  wire jog_s = pin_s_q[NUM_DI+1];

  // input function decode
  logic [NUM_DI-1:0] set2_v, halt_v;
  genvar g;
  generate
    for (g = 0; g < NUM_DI; g++) begin : g_di
      wire [FUNC_W-1:0] fn = di_fn_q[g*FUNC_W +: FUNC_W];
      assign set2_v[g] = di_s[g] && (fn == DI_FN_TIME_SET2);
      assign halt_v[g] = ((fn == DI_FN_HALT_NO) && di_s[g]) ||
        ((fn == DI_FN_HALT_NC) && !di_s[g]);
    end
  endgenerate
  wire halt_in = |halt_v;
  wire use_set2 = (|set2_v) || motor2_sel;

  // limits and targets
  wire [FREQ_W-1:0] fmax = motor2_sel ? fmax2_q : fmax1_q;
  wire [FREQ_W-1:0] upper = fmin(fmin(fmax1_q, fmax2_q), flim_q);
  wire [FREQ_W-1:0] fb_clamp = fmin(fb_q, upper);
  wire [FREQ_W-1:0] ref_clamp = fmin(freq_ref, fmin(fmax, flim_q));

  logic halt_q, run_prev_q;
  wire at_zero = out_freq_q == '0;
  wire run_rise = run_s && !run_prev_q;
  wire halt_clr = halt_q && at_zero && !halt_in && run_rise;
  wire halt_d = halt_in ? 1'b1 : (halt_clr ? 1'b0 : halt_q);
  wire stop_all = halt_q || fault_halt_req || !run_s;
  wire quick = halt_q || fault_halt_req;
  wire [FREQ_W-1:0] tgt = stop_all ? '0 :
    jog_s ? fmin(inch_q, upper) :
    pid_alarm ? fb_clamp : ref_clamp;
  wire up = tgt > out_freq_q;

  // active ramp time
  wire [TIME_W-1:0] t_norm = use_set2 ? (up ? acc2_q : dec2_q) :
    (up ? acc1_q : dec1_q);
  wire [TIME_W-1:0] t_jog = up ? iacc_q : idec_q;
  wire [TIME_W-1:0] t_sel = quick ? halt_t_q :
    (jog_s && run_s) ? t_jog : t_norm;
  wire [19:0] t_cs = unit_q ? 20'(t_sel) * 20'(DS_TO_CS) : 20'(t_sel);
  wire [16:0] s_sum = up ? 17'(sas_q) + 17'(sae_q) :
    17'(sds_q) + 17'(sde_q);
  wire [19:0] t_eff = t_cs + 20'(s_sum[16:1]);
  wire [TICKS_W-1:0] ticks = 24'(t_eff) * 24'(TICKS_PER_CS);

  // step computation
  dfrg_div_if div_bus ();
  logic div_req_q;
  logic [ACC_W-1:0] step_q;
  assign div_bus.req = div_req_q;
  assign div_bus.dividend = {fmax, {FRAC_W{1'b0}}};
  assign div_bus.divisor = ticks;

  dfrg_divider u_div (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ce(ce),
    .div(div_bus.slave)
  );

  // control tick
  logic [31:0] tick_cnt_q;
  wire tick = tick_cnt_q == 32'(TICK_CYCLES - 1);

  // ramp accumulator
  logic [ACC_W-1:0] acc_q;
  wire [ACC_W-1:0] tgt_acc = {tgt, {FRAC_W{1'b0}}};
  wire [ACC_W:0] acc_up = {1'b0, acc_q} + {1'b0, step_q};
  wire [ACC_W-1:0] gap_dn = acc_q - tgt_acc;
  wire [ACC_W-1:0] acc_nxt = up ?
    ((acc_up >= {1'b0, tgt_acc}) ? tgt_acc : acc_up[ACC_W-1:0]) :
    ((gap_dn <= step_q) ? tgt_acc : acc_q - step_q);
  wire [ACC_W-1:0] acc_d = tick ? acc_nxt : acc_q;
  wire halt_busy = quick && !at_zero;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tick_cnt_q <= '0;
      div_req_q <= 1'b0;
      step_q <= '0;
      acc_q <= '0;
      out_freq_q <= '0;
      halt_q <= 1'b0;
      run_prev_q <= 1'b0;
      halt_dout_q <= 1'b0;
      halt_latched_q <= 1'b0;
      at_target_q <= 1'b0;
    end else if (ce) begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 32'h0000_0001;
      div_req_q <= 1'b1;
      if (div_bus.done) begin
        step_q <= div_bus.quotient;
      end
      acc_q <= acc_d;
      out_freq_q <= acc_d[ACC_W-1:FRAC_W];
      halt_q <= halt_d;
      run_prev_q <= run_s;
      halt_latched_q <= halt_d;
      halt_dout_q <= halt_busy && (do_fn_q == DO_FN_HALT_BUSY);
      at_target_q <= acc_d[ACC_W-1:FRAC_W] == tgt;
    end
  end

  AST_HALT_LATCH: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && halt_in |=> halt_q)
    else $error("quick halt request not latched");

  AST_HALT_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && halt_q && !(at_zero && run_rise) |=> halt_q)
    else $error("quick halt released early");

  AST_HALT_NO_RUN: assert property (@(posedge mclk) disable iff (sys_rst)
    halt_q |-> tgt == '0 && t_sel == halt_t_q)
    else $error("target not zero during quick halt");

  AST_DOUT_HALT: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && halt_busy && do_fn_q == DO_FN_HALT_BUSY |=> halt_dout_q)
    else $error("halt output not asserted during decel");

  AST_SET2_ACC: assert property (@(posedge mclk) disable iff (sys_rst)
    !quick && !jog_s && (|set2_v) && up |-> t_sel == acc2_q)
    else $error("time set two not selected");

  AST_JOG_PRIO: assert property (@(posedge mclk) disable iff (sys_rst)
    !stop_all && jog_s |-> tgt == fmin(inch_q, upper) &&
    t_sel == (up ? iacc_q : idec_q))
    else $error("jog command not given priority");

  AST_FALLBACK: assert property (@(posedge mclk) disable iff (sys_rst)
    !stop_all && !jog_s && pid_alarm |-> tgt == fb_clamp && tgt <= upper)
    else $error("fallback frequency not applied");

  AST_RAMP_DIR: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && tick && up |=> acc_q >= $past(acc_q) && acc_q <= $past(tgt_acc))
    else $error("ramp overshoot or wrong direction");

  AST_RESET_OUT: assert property (@(posedge mclk)
    sys_rst |=> out_freq_q == '0 && !halt_latched_q)
    else $error("outputs not cleared by reset");
endmodule

// ---- include/dfrg_pkg.sv ----
package dfrg_pkg;
  // frequency in 0.01 Hz, ramp accumulator carries a 16-bit fraction
  localparam int FREQ_W = 16;
  localparam int FRAC_W = 16;
  localparam int ACC_W = FREQ_W + FRAC_W;
  localparam int TIME_W = 16;
  localparam int TICKS_W = 24;
  localparam int FUNC_W = 8;

  // input and output function codes
  localparam logic [7:0] DI_FN_TIME_SET2 = 8'h10;
  localparam logic [7:0] DI_FN_HALT_NO = 8'h15;
  localparam logic [7:0] DI_FN_HALT_NC = 8'h16;
  localparam logic [7:0] DO_FN_HALT_BUSY = 8'h2c;

  // time settings, counts of the selected time unit, except S-curve times, which are always 0.01 s counts
  localparam logic [15:0] RAMP_TIME_MAX = 16'hea60;
  localparam logic [15:0] HALT_TIME_MAX = 16'h8ca0;
  localparam logic [15:0] RAMP_TIME_DEF = 16'h0064;
  localparam logic [15:0] SCURVE_MAX = 16'h03e8;
  localparam logic [15:0] SCURVE_DEF = 16'h0014;
  localparam logic UNIT_SEL_DEF = 1'b1;
  localparam logic [3:0] DS_TO_CS = 4'ha;

  // frequency defaults, 0.01 Hz counts
  localparam logic [15:0] FALLBACK_DEF = 16'h0bb8;
  localparam logic [15:0] FMAX_DEF = 16'h1770;
  localparam logic [15:0] UPPER_LIMIT_DEF = 16'hffff;

  // control tick
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_TIME_NS = 1000000;
  localparam int TICK_CYCLES_DEF = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int CS_NS = 10000000;
  localparam logic [3:0] TICKS_PER_CS = 4'(CS_NS / TICK_TIME_NS);

  typedef enum logic [1:0] {
    DFRG_DIV_IDLE = 2'b01,
    DFRG_DIV_RUN = 2'b10
  } dfrg_div_state_t;
endpackage

// ---- include/dfrg_div_if.sv ----
`timescale 1ns/1ps
interface dfrg_div_if;
  import dfrg_pkg::*;
  logic req;
  logic [ACC_W-1:0] dividend;
  logic [TICKS_W-1:0] divisor;
  logic done;
  logic [ACC_W-1:0] quotient;
  modport master (output req, output dividend, output divisor,
    input done, input quotient);
  modport slave (input req, input dividend, input divisor,
    output done, output quotient);
endinterface

// ---- design/dfrg_divider.sv ----
`timescale 1ns/1ps
module dfrg_divider
  import dfrg_pkg::*;
(
  // clock, reset and enable
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  // division port
  dfrg_div_if.slave div
);
  dfrg_div_state_t state_q;
  logic [5:0] cnt_q;
  logic [ACC_W-1:0] num_q;
  logic [ACC_W-1:0] quo_q;
  logic [TICKS_W:0] rem_q;
  logic [TICKS_W-1:0] den_q;
  logic done_q;
  logic [ACC_W-1:0] res_q;
  wire [TICKS_W:0] rem_sh = {rem_q[TICKS_W-1:0], num_q[ACC_W-1]};
  wire rem_ge = rem_sh >= {1'b0, den_q};
  wire [TICKS_W:0] rem_sub = rem_sh - {1'b0, den_q};
  wire last = cnt_q == 6'(ACC_W - 1);

  assign div.done = done_q;
  assign div.quotient = res_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= DFRG_DIV_IDLE;
      cnt_q <= 6'h00;
      num_q <= '0;
      quo_q <= '0;
      rem_q <= '0;
      den_q <= '0;
      done_q <= 1'b0;
      res_q <= '0;
    end else if (ce) begin
      done_q <= 1'b0;
      case (state_q)
        DFRG_DIV_IDLE: begin
          if (div.req) begin
            num_q <= div.dividend;
            den_q <= div.divisor;
            rem_q <= '0;
            cnt_q <= 6'h00;
            state_q <= DFRG_DIV_RUN;
          end
        end
        DFRG_DIV_RUN: begin
          rem_q <= rem_ge ? rem_sub : rem_sh;
          num_q <= {num_q[ACC_W-2:0], 1'b0};
          quo_q <= {quo_q[ACC_W-2:0], rem_ge};
          cnt_q <= cnt_q + 6'h01;
          if (last) begin
            // zero divisor means an immediate jump: full step
            res_q <= (den_q == '0) ? '1 : {quo_q[ACC_W-2:0], rem_ge};
            done_q <= 1'b1;
            state_q <= DFRG_DIV_IDLE;
          end
        end
        default: state_q <= DFRG_DIV_IDLE;
      endcase
    end
  end

  property p_div_bounded;
    @(posedge mclk) disable iff (sys_rst)
      (ce && state_q == DFRG_DIV_IDLE && div.req) |=> ##[1:200] done_q;
  endproperty
  AST_DIV_DONE: assert property (p_div_bounded)
    else $error("divider did not finish");
endmodule

// ---- testbench/dfrg_term_model.sv ----
`timescale 1ns/1ps
module dfrg_term_model (
  // clock
  input wire logic mclk,
  // requests from the bench
  input wire logic halt_no,
  input wire logic halt_nc,
  input wire logic set2,
  // terminal pins
  output logic [3:0] di_pins
);
  logic [1:0] no_q = 2'h0;
  logic [1:0] nc_q = 2'h0;
  // a press is a momentary contact change, released by itself
  always @(posedge mclk) begin
    no_q <= halt_no ? 2'h3 : (no_q != 2'h0 ? no_q - 2'h1 : 2'h0);
    nc_q <= halt_nc ? 2'h3 : (nc_q != 2'h0 ? nc_q - 2'h1 : 2'h0);
  end
  // normally closed contact opens while pressed
  assign di_pins = {1'b0, set2, nc_q == 2'h0, no_q != 2'h0};
endmodule

// ---- testbench/drive_frequency_ramp_generator_tb.sv ----
`timescale 1ns/1ps
module drive_frequency_ramp_generator_tb;
  import dfrg_pkg::*;
  localparam int TK = 200;
  logic mclk, sys_rst, run_cmd, jog_req, pid_alarm, fault_halt_req;
  logic cfg_load, unit_sel, halt_no, halt_nc, set2, m2;
  logic [3:0] di_pins;
  logic [15:0] freq_ref, fm2, lim, fb, out_freq_q;
  logic [15:0] t[8];
  logic [15:0] s[4];
  logic halt_dout_q, halt_latched_q, at_target_q;
  int failures, total_checks, e, r;
  int cyc = 0;

  dfrg_term_model term (.mclk(mclk), .halt_no(halt_no),
    .halt_nc(halt_nc), .set2(set2), .di_pins(di_pins));

  dfrg_ramp_gen #(.NUM_DI(4), .TICK_CYCLES(TK)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .ce(1'b1), .di_pins(di_pins),
    .run_cmd(run_cmd), .jog_req(jog_req), .motor2_sel(m2),
    .pid_alarm(pid_alarm), .fault_halt_req(fault_halt_req),
    .freq_ref(freq_ref), .cfg_load(cfg_load),
    .accel_time_set1(t[0]), .decel_time_set1(t[1]),
    .accel_time_set2(t[2]), .decel_time_set2(t[3]),
    .quick_halt_time(t[4]), .ramp_time_unit_select(unit_sel),
    .inch_accel_time(t[5]), .inch_decel_time(t[6]),
    .scurve_accel_start(s[0]), .scurve_accel_end(s[1]),
    .scurve_decel_start(s[2]), .scurve_decel_end(s[3]),
    .max_output_freq(16'd6000), .motor2_max_output_freq(fm2),
    .freq_cmd_upper_limit(lim), .inch_freq_cmd(t[7]),
    .disconnect_fallback_freq(fb),
    .digital_input_function_select({8'h00, DI_FN_TIME_SET2,
      DI_FN_HALT_NC, DI_FN_HALT_NO}),
    .digital_output_function_select(DO_FN_HALT_BUSY),
    .out_freq_q(out_freq_q), .halt_dout_q(halt_dout_q),
    .halt_latched_q(halt_latched_q), .at_target_q(at_target_q));

  task automatic finish_test();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // model: step per tick toward the target, last step clipped
  task automatic ramp(input int tgt, input int st, input bit hd);
    int n;
    while (e != tgt) begin
      n = 0;
      @(negedge mclk);
      while (out_freq_q === 16'(e) && n < 3 * TK) begin
        @(negedge mclk);
        n++;
      end
      e = (e < tgt) ? ((e + st > tgt) ? tgt : e + st)
                    : ((e - st < tgt) ? tgt : e - st);
      chk(out_freq_q, 16'(e));
      if (hd && e != 0) chk(16'(halt_dout_q), 16'h1);
    end
    repeat (3) @(negedge mclk);
    chk(16'(at_target_q), 16'h1);
    @(posedge mclk);
  endtask

  // changes land just after a tick so the divider settles first
  task automatic align();
    @(posedge mclk);
    while (cyc % TK != 10) @(posedge mclk);
  endtask

  task automatic cfg();
    cfg_load <= 1'b1;
    @(posedge mclk);
    cfg_load <= 1'b0;
  endtask

  task automatic go(input int f, input int st);
    align();
    freq_ref <= 16'(f);
    ramp(f, st, 0);
  endtask

  task automatic halt_seq(input bit nc);
    go(3000, 600);
    align();
    if (nc) halt_nc <= 1'b1;
    else halt_no <= 1'b1;
    @(posedge mclk);
    halt_no <= 1'b0;
    halt_nc <= 1'b0;
    repeat (6) @(negedge mclk);
    chk(16'(halt_latched_q), 16'h1);
    chk(16'(halt_dout_q), 16'h1);
    ramp(0, 200, 1);
    repeat (2 * TK) @(negedge mclk);
    chk(out_freq_q, 16'h0);
    chk(16'(halt_latched_q), 16'h1);
    align();
    run_cmd <= 1'b0;
    repeat (4) @(posedge mclk);
    run_cmd <= 1'b1;
    repeat (6) @(negedge mclk);
    chk(16'(halt_latched_q), 16'h0);
    ramp(3000, 600, 0);
    go(0, 300);
  endtask

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= sys_rst ? 0 : cyc + 1;
    if (cyc > 90000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    void'($urandom(32'h19ce));
    sys_rst = 1'b1;
    {run_cmd, jog_req, pid_alarm, fault_halt_req} = 4'h0;
    {cfg_load, unit_sel, halt_no, halt_nc, set2, m2} = 6'h0;
    freq_ref = 16'h0;
    fm2 = 16'd6000;
    lim = 16'hffff;
    fb = 16'd4000;
    t = '{16'h1, 16'h2, 16'h3, 16'h5, 16'h3, 16'h2, 16'h5, 16'h0};
    s = '{default: 16'h0};
    failures = 0;
    total_checks = 0;
    e = 0;
    r = $urandom_range(1000, 3000);
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    @(negedge mclk);
    chk({out_freq_q[14:0], halt_dout_q}, 16'h0);
    chk({halt_latched_q, at_target_q}, 16'h0);
    align();
    cfg();
    run_cmd <= 1'b1;
    go(r, 600);
    go(0, 300);
    align();
    set2 <= 1'b1;
    go(r, 200);
    go(0, 120);
    set2 <= 1'b0;
    s <= '{16'h1, 16'h1, 16'h4, 16'h2};
    align();
    cfg();
    go(r, 300);
    go(0, 120);
    s <= '{default: 16'h0};
    unit_sel <= 1'b1;
    align();
    cfg();
    go(600, 60);
    unit_sel <= 1'b0;
    align();
    cfg();
    go(0, 300);
    halt_seq(1'b0);
    halt_seq(1'b1);
    go(3000, 600);
    align();
    fault_halt_req <= 1'b1;
    freq_ref <= 16'h0;
    ramp(0, 200, 1);
    chk(16'(halt_latched_q), 16'h0);
    fault_halt_req <= 1'b0;
    t[7] <= 16'd1500;
    align();
    cfg();
    jog_req <= 1'b1;
    ramp(1500, 300, 0);
    t[7] <= 16'd600;
    align();
    cfg();
    ramp(600, 120, 0);
    align();
    jog_req <= 1'b0;
    ramp(0, 300, 0);
    fm2 <= 16'd2400;
    align();
    cfg();
    pid_alarm <= 1'b1;
    freq_ref <= 16'd1000;
    ramp(2400, 600, 0);
    align();
    pid_alarm <= 1'b0;
    ramp(1000, 300, 0);
    align();
    m2 <= 1'b1;
    freq_ref <= 16'd2000;
    ramp(2000, 80, 0);
    finish_test();
  end
endmodule
